//--- core/output_pin_select_with_lock.sv
// Local design decisions: the address-and-strobe port and the register addresses.
`timescale 1ns/1ps
`include "pin_route_regs.svh"

// Notes on behaviour
// - pin register writes land in output latch
// - pin register reads return sampled pad levels
// - eight-bit latch drives plain output pins
// - select uses bits 4-0, upper read zero
// - codes 01 to 1B pick distinct peripherals
// - each source allowed on any of the eight ports
// - routed peripheral overrides direction when needed
// - lock set blocks all select writes
// - lock clear lets select writes apply
// - lock register implements bit zero only
// - direction one makes input, zero output
module output_pin_select_with_lock (
    // clock and reset
    input  wire logic        mclk,
    input  wire logic        resetn,
    // register port
    input  wire logic [5:0]  addr,
    input  wire logic [7:0]  wdata,
    input  wire logic        wstrobe,
    input  wire logic        rstrobe,
    output logic      [7:0]  rdata,
    // peripheral outputs, index = source code
    input  wire logic [27:0] periphOut,
    input  wire logic [27:0] periphDrive,
    // port d pads
    input  wire logic [7:0]  padIn,
    output logic      [7:0]  padOut,
    output logic      [7:0]  padOe
);

    pin_route_pkg::state_t s_q;
    pin_route_pkg::state_t s_d;

    logic selWrite;
    logic [2:0] selIdx;

    assign selWrite = wstrobe && addr >= `ADDR_SEL_BASE && addr <= `ADDR_SEL_LAST;
    assign selIdx   = addr[2:0];

    always_comb begin
        pin_route_pkg::srcCode_t code;
        code = `RST_SEL;
        s_d = s_q;
        s_d.rdata = `RST_RDATA;
        if (wstrobe) begin
            unique case (addr)
                `ADDR_PORT_D_PIN_REGISTER_PIN: s_d.lat = wdata;
                `ADDR_PORT_D_PIN_REGISTER_LAT: s_d.lat = wdata;
                `ADDR_PORT_D_PIN_REGISTER_DIR: s_d.dir = wdata;
                `ADDR_LOCK:      s_d.lock = wdata[`LOCK_BIT];
                default: begin
                    if (selWrite && !s_q.lock) begin
                        s_d.sel[selIdx] = wdata[`SEL_MSB:0];
                    end
                end
            endcase
        end
        if (rstrobe) begin
            unique case (addr)
                `ADDR_PORT_D_PIN_REGISTER_PIN: s_d.rdata = padIn;
                `ADDR_PORT_D_PIN_REGISTER_LAT: s_d.rdata = s_q.lat;
                `ADDR_PORT_D_PIN_REGISTER_DIR: s_d.rdata = s_q.dir;
                `ADDR_LOCK:      s_d.rdata = {7'h00, s_q.lock};
                default: begin
                    if (addr >= `ADDR_SEL_BASE && addr <= `ADDR_SEL_LAST) begin
                        s_d.rdata = {3'h0, s_q.sel[selIdx]};
                    end
                end
            endcase
        end
        // routing uses current selections; one flop of latency to the pad
        for (int p = 0; p < 8; p++) begin
            code = s_q.sel[p];
            if (code >= `SRC_FIRST && code <= `SRC_LAST) begin
                s_d.padOut[p] = periphOut[code];
                s_d.padOe[p]  = periphDrive[code] | ~s_q.dir[p];
            end else begin
                s_d.padOut[p] = s_q.lat[p];
                s_d.padOe[p]  = ~s_q.dir[p];
            end
        end
    end

    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            for (int p = 0; p < 8; p++) begin
                s_q.sel[p] <= `RST_SEL;
            end
            s_q.lock   <= `RST_LOCK;
            s_q.lat    <= `RST_LAT;
            s_q.dir    <= `RST_DIR;
            s_q.padOut <= `RST_LAT;
            s_q.padOe  <= `RST_LAT;
            s_q.rdata  <= `RST_RDATA;
        end else begin
            s_q <= s_d;
        end
    end

    assign rdata  = s_q.rdata;
    assign padOut = s_q.padOut;
    assign padOe  = s_q.padOe;

    a_lock_holds_sel: assert property (@(posedge mclk) disable iff (!resetn)
        s_q.lock |=> $stable(s_q.sel)) else $error("selection changed while locked");
    a_unlock_write: assert property (@(posedge mclk) disable iff (!resetn)
        (selWrite && !s_q.lock) |=> s_q.sel[$past(selIdx)] == $past(wdata[4:0]))
        else $error("unlocked select write lost");
    a_pin_write_lat: assert property (@(posedge mclk) disable iff (!resetn)
        (wstrobe && addr == `ADDR_PORT_D_PIN_REGISTER_PIN) |=> s_q.lat == $past(wdata))
        else $error("pin write missed latch");
    a_pin_read_pad: assert property (@(posedge mclk) disable iff (!resetn)
        (rstrobe && addr == `ADDR_PORT_D_PIN_REGISTER_PIN) |=> rdata == $past(padIn))
        else $error("pin read not pad level");
    a_lock_read_zero: assert property (@(posedge mclk) disable iff (!resetn)
        (rstrobe && addr == `ADDR_LOCK) |=> rdata[7:1] == 7'h00)
        else $error("lock upper bits nonzero");
    a_sel_read_zero: assert property (@(posedge mclk) disable iff (!resetn)
        (rstrobe && selWrite == 1'b0 && addr >= `ADDR_SEL_BASE) |=> rdata[7:5] == 3'h0)
        else $error("select upper bits nonzero");
    a_fallback_latch: assert property (@(posedge mclk) disable iff (!resetn)
        (s_q.sel[0] == 5'h00) |=> padOut[0] == $past(s_q.lat[0]) && padOe[0] == !$past(s_q.dir[0]))
        else $error("unrouted pin not from latch");
    a_route_src: assert property (@(posedge mclk) disable iff (!resetn)
        (s_q.sel[0] == 5'h1B) |=> padOut[0] == $past(periphOut[27]))
        else $error("routed source wrong");
    a_override_dir: assert property (@(posedge mclk) disable iff (!resetn)
        (s_q.sel[1] != 5'h00 && s_q.sel[1] <= 5'h1B && periphDrive[s_q.sel[1]]) |=> padOe[1])
        else $error("peripheral did not override direction");

    c_locked_write: cover property (@(posedge mclk) disable iff (!resetn) s_q.lock && selWrite);
    c_sel_write:    cover property (@(posedge mclk) disable iff (!resetn) !s_q.lock && selWrite);
    c_pin_read:     cover property (@(posedge mclk) disable iff (!resetn)
        rstrobe && addr == `ADDR_PORT_D_PIN_REGISTER_PIN);
    c_routed:       cover property (@(posedge mclk) disable iff (!resetn) s_q.sel[2] != 5'h00);

endmodule

//--- core/pin_route_regs.svh
`ifndef PIN_ROUTE_REGS_SVH
`define PIN_ROUTE_REGS_SVH

// register index map (byte-wide registers on a plain port)
`define ADDR_W          6
`define ADDR_PORT_D_PIN_REGISTER_PIN  6'h00
`define ADDR_PORT_D_PIN_REGISTER_LAT  6'h01
`define ADDR_PORT_D_PIN_REGISTER_DIR  6'h02
`define ADDR_LOCK       6'h03
`define ADDR_SEL_BASE   6'h08
`define ADDR_SEL_LAST   6'h0F

// field layout
`define SEL_MSB         4
`define LOCK_BIT        0

// reset values
`define RST_SEL         5'h00
`define RST_LOCK        1'b0
`define RST_LAT         8'h00
`define RST_DIR         8'hFF
`define RST_RDATA       8'h00

// source codes
`define SRC_FIRST       5'h01
`define SRC_LAST        5'h1B
`define SRC_COUNT       28

`endif

//--- core/pin_route_pkg.sv
package pin_route_pkg;

    typedef logic [4:0] srcCode_t;

    typedef struct packed {
        srcCode_t [7:0] sel;
        logic           lock;
        logic [7:0]     lat;
        logic [7:0]     dir;
        logic [7:0]     padOut;
        logic [7:0]     padOe;
        logic [7:0]     rdata;
    } state_t;

endpackage

//--- sim/periph_pad_model.sv
`timescale 1ns/1ps
module periph_pad_model (
    // bench controls
    input  wire logic [27:0] srcVal,
    input  wire logic [27:0] srcDrv,
    input  wire logic [7:0]  extLevel,
    // block side
    input  wire logic [7:0]  padOut,
    input  wire logic [7:0]  padOe,
    output logic      [7:0]  padIn,
    output logic      [27:0] periphOut,
    output logic      [27:0] periphDrive
);
    assign periphOut   = srcVal;
    assign periphDrive = srcDrv;
    // released pad shows the outside level, never the last driven value
    assign padIn = (padOe & padOut) | (~padOe & extLevel);
endmodule

//--- sim/testbench.sv
`timescale 1ns/1ps
module testbench;
    logic        mclk, resetn, wstrobe, rstrobe;
    logic [5:0]  addr;
    logic [7:0]  wdata, rdata, padIn, padOut, padOe, extLevel;
    logic [27:0] periphOut, periphDrive, srcVal, srcDrv;
    int          n_mismatch, check_count;

    output_pin_select_with_lock DUT (.mclk(mclk), .resetn(resetn), .addr(addr), .wdata(wdata),
        .wstrobe(wstrobe), .rstrobe(rstrobe), .rdata(rdata), .periphOut(periphOut),
        .periphDrive(periphDrive), .padIn(padIn), .padOut(padOut), .padOe(padOe));
    periph_pad_model PARTNER (.srcVal(srcVal), .srcDrv(srcDrv), .extLevel(extLevel),
        .padOut(padOut), .padOe(padOe), .padIn(padIn), .periphOut(periphOut),
        .periphDrive(periphDrive));

    task automatic chk(string n, logic [7:0] e, logic [7:0] g);
        check_count++;
        if (g !== e) begin
            n_mismatch++;
            $display("ERROR %s expected %h seen %h", n, e, g);
        end
    endtask
    task automatic wr(logic [5:0] a, logic [7:0] d);
        @(posedge mclk);
        addr    <= a;
        wdata   <= d;
        wstrobe <= 1'h1;
        @(posedge mclk);
        wstrobe <= 1'h0;
    endtask
    // read data stand only in the cycle after the strobe
    task automatic rd(string n, logic [5:0] a, logic [7:0] e);
        @(posedge mclk);
        addr    <= a;
        rstrobe <= 1'h1;
        @(posedge mclk);
        rstrobe <= 1'h0;
        #1 chk(n, e, rdata);
    endtask
    task automatic pads(logic [7:0] eo, logic [7:0] ee);
        @(posedge mclk);
        #1 chk("padOut", eo, padOut);
        chk("padOe", ee, padOe);
    endtask
    task automatic t_latch;
        rd("dir reset", 6'h02, 8'hFF);
        wr(6'h00, 8'hA5);
        rd("latch", 6'h01, 8'hA5);
        rd("pin", 6'h00, 8'h3C);
        wr(6'h02, 8'h0F);
        pads(8'hA5, 8'hF0);
        rd("pin mixed", 6'h00, 8'hAC);
        wr(6'h02, 8'hFF);
        wr(6'h01, 8'h00);
    endtask
    task automatic t_codes;
        rd("sel reset", 6'h08, 8'h00);
        wr(6'h08, 8'hFF);
        rd("sel upper", 6'h08, 8'h1F);
        for (int c = 1; c <= 27; c++) begin
            @(posedge mclk);
            srcVal <= 28'h1 << c;
            srcDrv <= 28'h1 << c;
            wr(6'h08, 8'(c));
            pads(8'h01, 8'h01);
        end
        wr(6'h01, 8'h01);
        wr(6'h08, 8'h1C);
        pads(8'h01, 8'h00);
        wr(6'h01, 8'h00);
    endtask
    task automatic t_lock;
        rd("lock reset", 6'h03, 8'h00);
        wr(6'h03, 8'hFF);
        rd("lock read", 6'h03, 8'h01);
        wr(6'h09, 8'h03);
        rd("sel locked", 6'h09, 8'h00);
        wr(6'h03, 8'h00);
        wr(6'h09, 8'h03);
        rd("sel unlocked", 6'h09, 8'h03);
        rd("unmapped", 6'h3F, 8'h00);
    endtask
    task automatic test_done;
        if (n_mismatch == 0 && check_count > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask

    initial begin
        mclk = 1'h0;
        forever #5 mclk = ~mclk;
    end
    initial begin
        {resetn, wstrobe, rstrobe, addr, wdata, srcVal, srcDrv} = '0;
        extLevel = 8'h3C;
        repeat (5) @(posedge mclk);
        resetn <= 1'h1;
        t_latch;
        t_codes;
        t_lock;
        test_done;
    end
    // whole run is about 160 cycles
    initial begin
        #100000;
        n_mismatch++;
        test_done;
    end
endmodule
